/* reset_partner.sv */
/*
 * External reset circuit: open-drain reset pin with pull-up and a push button.
 * Assumes the design raises its output enable while pulling the pin low.
 */
`timescale 1ns/1ps
`default_nettype none
module reset_partner (
    input wire logic clk_sys_i,
    input wire logic rst_pin_i,
    input wire logic rst_pin_oe_i,
    output logic rst_pin_b_o
);
    logic btn_low_reg = 1'b0;
    // Pull-up level unless either party pulls the line low.
    assign rst_pin_b_o = !((rst_pin_oe_i && !rst_pin_i) || btn_low_reg);
    task automatic press(input int n);
        @(negedge clk_sys_i);
        btn_low_reg = 1'b1;
        repeat (n) @(negedge clk_sys_i);
        btn_low_reg = 1'b0;
    endtask : press
endmodule : reset_partner
`default_nettype wire

/* reset_source_sequencer.sv */
/*
 * Reset source sequencer: combines power-on, power-fail, watchdog and manual
 * reset into one core reset with a fixed restart address.
 * Assumes supply comparators are already clean and glitch filtered, and that
 * the reset pin is open-drain with an external pull-up.
 */
// Functional notes
// R1 - Power-on reset clears every register; the code sets core_rst_reg and por_flag_reg to one instead.
// R2 - Power-on sets watchdog control bit seven.
// R3 - Power-on selects ring oscillator clock.
// R4 - Power-on release presents restart address 8000h.
// R5 - Hold 65536 oscillator cycles after supplies good.
// R6 - Hold counter idle during normal operation.
// R7 - Power-fail asserts reset during operation.
// R8 - Software restarts watchdog before it expires.
// R9 - Optional early warning interrupt precedes watchdog reset.
// R10 - Watchdog reset lasts four clocks, restart 8000h.
// R11 - Manual reset pin held low four clocks.
// R12 - Leave reset within four clocks of pin release.
// R13 - Open-drain pin driven low during reset; the code releases the pin while in ST_MANUAL.
// R14 - OR all sources, release synchronously.
`timescale 1ns/1ps
`default_nettype none
module reset_source_sequencer #(
    parameter int unsigned HOLD_CYCLES = reset_source_sequencer_pkg::POWERUP_HOLD_CYCLES
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic vddc_ok_i,
    input wire logic vddio_ok_i,
    input wire logic power_fail_i,
    input wire logic rst_pin_b_i,
    output logic rst_pin_o,
    output logic rst_pin_oe_o,
    input wire logic wdog_enable_i,
    input wire logic wdog_warn_enable_i,
    input wire logic wdog_restart_i,
    input wire logic wdog_por_flag_clear_i,
    input wire logic [reset_source_sequencer_pkg::WDOG_CNT_W-1:0] wdog_timeout_i,
    input wire logic [reset_source_sequencer_pkg::WDOG_CNT_W-1:0] wdog_warn_i,
    output logic wdog_irq_o,
    output logic [7:0] watchdog_control_o,
    output logic clk_sel_o,
    output logic core_rst_o,
    output logic [15:0] restart_addr_o
);
    import reset_source_sequencer_pkg::*;

    // ----------------------------------------------------------------
    // Input synchronisers.
    // ----------------------------------------------------------------
    logic [2:0] pin_sync_reg, pin_sync_next;
    logic [2:0] pf_sync_reg, pf_sync_next;
    logic [2:0] sup_sync_reg, sup_sync_next;
    logic pin_low_reg, pin_low_next;
    logic pf_reg, pf_next;
    logic sup_ok_reg, sup_ok_next;

    always_comb begin
        pin_sync_next = {pin_sync_reg[1:0], ~rst_pin_b_i};
        pf_sync_next = {pf_sync_reg[1:0], power_fail_i};
        sup_sync_next = {sup_sync_reg[1:0], vddc_ok_i & vddio_ok_i};
        pin_low_next = (pin_sync_reg[2] == pin_sync_reg[1]) ? pin_sync_reg[2] : pin_low_reg;
        pf_next = (pf_sync_reg[2] == pf_sync_reg[1]) ? pf_sync_reg[2] : pf_reg;
        sup_ok_next = (sup_sync_reg[2] == sup_sync_reg[1]) ? sup_sync_reg[2] : sup_ok_reg;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_sync_reg <= 3'h0;
            pf_sync_reg <= 3'h0;
            sup_sync_reg <= 3'h0;
            pin_low_reg <= 1'b0;
            pf_reg <= 1'b0;
            sup_ok_reg <= 1'b0;
        end else begin
            pin_sync_reg <= pin_sync_next;
            pf_sync_reg <= pf_sync_next;
            sup_sync_reg <= sup_sync_next;
            pin_low_reg <= pin_low_next;
            pf_reg <= pf_next;
            sup_ok_reg <= sup_ok_next;
        end
    end

    // ----------------------------------------------------------------
    // Power-up hold and reset state machine.
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {ST_POWERUP, ST_RUN, ST_WDOG, ST_MANUAL, ST_FAIL} seq_state_e;
    seq_state_e state_reg, state_next;
    logic [HOLD_CNT_W-1:0] hold_cnt_reg, hold_cnt_next;
    logic [2:0] wrst_cnt_reg, wrst_cnt_next;
    logic [2:0] man_cnt_reg, man_cnt_next;
    logic wdog_fire;
    logic in_reset;

    always_comb begin
        state_next = state_reg;
        hold_cnt_next = hold_cnt_reg;
        wrst_cnt_next = wrst_cnt_reg;
        man_cnt_next = man_cnt_reg;
        if (rst_pin_oe_o) begin
            man_cnt_next = 3'(MANUAL_MIN_CYCLES); // R13
        end else if (!pin_low_reg) begin
            man_cnt_next = 3'h0;
        end else if (man_cnt_reg != 3'(MANUAL_MIN_CYCLES)) begin
            man_cnt_next = man_cnt_reg + 3'h1; // R11
        end
        unique case (state_reg)
            ST_POWERUP: begin
                if (!sup_ok_reg) begin
                    hold_cnt_next = '0; // R5
                end else if (hold_cnt_reg == HOLD_CNT_W'(HOLD_CYCLES - 1)) begin
                    state_next = ST_RUN; // R6
                end else begin
                    hold_cnt_next = hold_cnt_reg + 1'b1; // R5
                end
            end
            ST_RUN: begin
                if (pf_reg) begin
                    state_next = ST_FAIL; // R7
                end else if (wdog_fire) begin
                    state_next = ST_WDOG; // R10
                    wrst_cnt_next = 3'h0;
                end else if (man_cnt_reg == 3'(MANUAL_MIN_CYCLES - 1) && pin_low_reg) begin
                    state_next = ST_MANUAL; // R11
                end
            end
            ST_WDOG: begin
                wrst_cnt_next = wrst_cnt_reg + 3'h1;
                if (wrst_cnt_reg == 3'(WDOG_RESET_CYCLES - 1)) begin
                    state_next = ST_RUN; // R10
                end
            end
            ST_MANUAL: begin
                if (!pin_low_next) begin
                    state_next = ST_RUN; // R12
                end
            end
            ST_FAIL: begin
                if (!pf_reg) begin
                    state_next = ST_RUN; // R7
                end
            end
            default: begin
                state_next = ST_POWERUP;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_reg <= ST_POWERUP; // R1
            hold_cnt_reg <= '0;
            wrst_cnt_reg <= 3'h0;
            man_cnt_reg <= 3'h0;
        end else begin
            state_reg <= state_next;
            hold_cnt_reg <= hold_cnt_next;
            wrst_cnt_reg <= wrst_cnt_next;
            man_cnt_reg <= man_cnt_next;
        end
    end

    // ----------------------------------------------------------------
    // Combined reset, pin drive and restart address.
    // ----------------------------------------------------------------
    logic core_rst_reg, core_rst_next;
    logic clk_sel_reg, clk_sel_next;

    assign in_reset = state_next != ST_RUN; // R14

    always_comb begin
        core_rst_next = in_reset; // R14
        clk_sel_next = clk_sel_reg;
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            core_rst_reg <= 1'b1;
            clk_sel_reg <= CLK_SEL_RING; // R3
        end else begin
            core_rst_reg <= core_rst_next;
            clk_sel_reg <= clk_sel_next;
        end
    end

    assign core_rst_o = core_rst_reg;
    assign clk_sel_o = clk_sel_reg;
    assign restart_addr_o = RESTART_ADDR; // R4
    assign rst_pin_o = 1'b0;
    assign rst_pin_oe_o = core_rst_reg && state_reg != ST_MANUAL; // R13

    // ----------------------------------------------------------------
    // Watchdog with early warning and power-on flag.
    // ----------------------------------------------------------------
    logic [WDOG_CNT_W-1:0] wdog_cnt_reg, wdog_cnt_next;
    logic wdog_irq_reg, wdog_irq_next;
    logic por_flag_reg, por_flag_next;

    assign wdog_fire = wdog_enable_i && !core_rst_reg && wdog_cnt_reg >= wdog_timeout_i; // R8

    always_comb begin
        wdog_cnt_next = wdog_cnt_reg;
        wdog_irq_next = wdog_irq_reg;
        por_flag_next = por_flag_reg;
        if (core_rst_reg || !wdog_enable_i || wdog_restart_i) begin
            wdog_cnt_next = '0;
            wdog_irq_next = 1'b0;
        end else begin
            wdog_cnt_next = wdog_cnt_reg + 1'b1;
            if (wdog_warn_enable_i && wdog_cnt_reg >= wdog_warn_i) begin
                wdog_irq_next = 1'b1; // R9
            end
        end
        if (state_reg == ST_POWERUP) begin
            por_flag_next = 1'b1; // R2
        end else if (wdog_por_flag_clear_i) begin
            por_flag_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            wdog_cnt_reg <= '0;
            wdog_irq_reg <= 1'b0;
            por_flag_reg <= 1'b1; // R2
        end else begin
            wdog_cnt_reg <= wdog_cnt_next;
            wdog_irq_reg <= wdog_irq_next;
            por_flag_reg <= por_flag_next;
        end
    end

    assign wdog_irq_o = wdog_irq_reg;
    always_comb begin
        watchdog_control_o = WDCTL_RESET_VAL;
        watchdog_control_o[WDCTL_POR_BIT] = por_flag_reg;
        watchdog_control_o[0] = wdog_irq_reg;
    end

    // ----------------------------------------------------------------
    // Assertions.
    // ----------------------------------------------------------------
    property p_por_flag;
        @(posedge clk_sys_i) disable iff (!rst_b_i) state_reg == ST_POWERUP |=> por_flag_reg;
    endproperty
    a_por_flag: assert property (p_por_flag) else $error("por flag not set"); // R2

    property p_hold;
        @(posedge clk_sys_i) disable iff (!rst_b_i) $fell(core_rst_reg) |->
            $past(state_reg) != ST_POWERUP || $past(hold_cnt_reg) == HOLD_CNT_W'(HOLD_CYCLES - 1);
    endproperty
    a_hold: assert property (p_hold) else $error("reset released during hold"); // R5

    property p_hold_idle;
        @(posedge clk_sys_i) disable iff (!rst_b_i) state_reg != ST_POWERUP |-> $stable(hold_cnt_reg);
    endproperty
    a_hold_idle: assert property (p_hold_idle) else $error("hold counter moved"); // R6

    property p_fail;
        @(posedge clk_sys_i) disable iff (!rst_b_i) pf_reg && state_reg == ST_RUN |=> core_rst_reg;
    endproperty
    a_fail: assert property (p_fail) else $error("power fail ignored"); // R7

    property p_wdog_len;
        @(posedge clk_sys_i) disable iff (!rst_b_i) $rose(state_reg == ST_WDOG) |->
            core_rst_reg[*4] ##1 (!core_rst_reg || pf_reg);
    endproperty
    a_wdog_len: assert property (p_wdog_len) else $error("watchdog reset length wrong"); // R10

    property p_manual_exit;
        @(posedge clk_sys_i) disable iff (!rst_b_i) state_reg == ST_MANUAL && rst_pin_b_i |->
            ##[1:4] (!core_rst_reg || pf_reg || !rst_pin_b_i);
    endproperty
    a_manual_exit: assert property (p_manual_exit) else $error("manual exit late"); // R12

    property p_pin_drive;
        @(posedge clk_sys_i) disable iff (!rst_b_i) state_reg != ST_RUN && state_reg != ST_MANUAL |->
            rst_pin_oe_o && !rst_pin_o;
    endproperty
    a_pin_drive: assert property (p_pin_drive) else $error("pin not driven low"); // R13

    property p_or;
        @(posedge clk_sys_i) disable iff (!rst_b_i) state_reg != ST_RUN |-> core_rst_reg;
    endproperty
    a_or: assert property (p_or) else $error("combined reset missing"); // R14

    property p_warn;
        @(posedge clk_sys_i) disable iff (!rst_b_i) wdog_irq_reg && !wdog_restart_i && wdog_enable_i && !core_rst_reg |=>
            wdog_irq_reg || core_rst_reg;
    endproperty
    a_warn: assert property (p_warn) else $error("warning dropped"); // R9
endmodule : reset_source_sequencer
`default_nettype wire

/* reset_source_sequencer_pkg.sv */
/*
 * Package for the reset source sequencer: timing counts, reset values and the
 * fixed restart address. Assumes a single system clock domain.
 */
package reset_source_sequencer_pkg;
    localparam int unsigned POWERUP_HOLD_CYCLES = 65536;
    localparam int unsigned HOLD_CNT_W = 17;
    localparam int unsigned WDOG_RESET_CYCLES = 4;
    localparam int unsigned MANUAL_MIN_CYCLES = 4;
    localparam int unsigned RELEASE_MAX_CYCLES = 4;
    localparam logic [15:0] RESTART_ADDR = 16'h8000;
    localparam int unsigned WDCTL_POR_BIT = 7;
    localparam logic [7:0] WDCTL_RESET_VAL = 8'h00;
    localparam logic CLK_SEL_RING = 1'b0;
    localparam int unsigned WDOG_CNT_W = 16;
    localparam logic [15:0] WDOG_TIMEOUT_DEF = 16'hffff;
    localparam logic [15:0] WDOG_WARN_DEF = 16'hc000;
endpackage : reset_source_sequencer_pkg

/* tb_top.sv */
/*
 * Testbench for the reset source sequencer with a behavioural timing model.
 * Assumes the partner model supplies the pin and the bench drives the rest.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import reset_source_sequencer_pkg::*;
    localparam int HOLD = 16;
    logic clk_sys_i = 1'b0;
    logic rst_b_i, vddc, vddio, pfail, pin_b, pin, oe, wen, wwen, wrst, pclr, irq, csel, core;
    logic [15:0] tmo, wrn, raddr;
    logic [7:0] wdctl;
    int num_errors = 0, n_compared = 0, cycles = 0, seed = 71726, n, t;
    always #2.5 clk_sys_i = !clk_sys_i;
    reset_partner u_reset_partner (.clk_sys_i(clk_sys_i), .rst_pin_i(pin), .rst_pin_oe_i(oe), .rst_pin_b_o(pin_b));
    reset_source_sequencer #(.HOLD_CYCLES(HOLD)) u_reset_source_sequencer (
        .clk_sys_i(clk_sys_i), .rst_b_i(rst_b_i), .vddc_ok_i(vddc), .vddio_ok_i(vddio),
        .power_fail_i(pfail), .rst_pin_b_i(pin_b), .rst_pin_o(pin), .rst_pin_oe_o(oe),
        .wdog_enable_i(wen), .wdog_warn_enable_i(wwen), .wdog_restart_i(wrst),
        .wdog_por_flag_clear_i(pclr), .wdog_timeout_i(tmo), .wdog_warn_i(wrn), .wdog_irq_o(irq),
        .watchdog_control_o(wdctl), .clk_sel_o(csel), .core_rst_o(core), .restart_addr_o(raddr));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk
    task automatic rng(input string what, input int v, input int lo, input int hi);
        n_compared++;
        if (v < lo || v > hi) begin
            num_errors++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", what, lo, hi, v);
        end
    endtask : rng
    task automatic wait_core(input logic v, input int lim, output int cnt);
        cnt = 0;
        while (core !== v && cnt < lim) begin
            @(negedge clk_sys_i);
            cnt++;
        end
    endtask : wait_core
    task automatic conclude();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : conclude
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        {rst_b_i, vddc, vddio, pfail, wen, wwen, wrst, pclr} = 8'h00;
        t = 24 + ($random(seed) & 15);
        tmo = 16'(t);
        wrn = 16'(t / 2);
        repeat (20) @(negedge clk_sys_i);
        chk("core_rst", 1, core);
        chk("pin_oe", 1, oe);
        chk("por_flag", 1, wdctl[WDCTL_POR_BIT]);
        chk("clk_sel", CLK_SEL_RING, csel);
        chk("irq", 0, irq);
        rst_b_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        {vddc, vddio} = 2'b11;
        wait_core(0, HOLD + 40, n);
        rng("powerup_hold", n, HOLD, HOLD + 8);
        chk("restart_addr", RESTART_ADDR, raddr);
        $display("test powerup done");
        repeat (8) @(negedge clk_sys_i);
        u_reset_partner.press(2);
        repeat (12) @(negedge clk_sys_i);
        chk("short_press", 0, core);
        fork
            u_reset_partner.press(14);
            begin
                wait_core(1, 14, n);
                chk("manual_rst", 1, core);
            end
        join
        wait_core(0, 20, n);
        rng("manual_exit", n, 1, RELEASE_MAX_CYCLES);
        chk("restart_addr", RESTART_ADDR, raddr);
        $display("test manual done");
        pclr = 1'b1;
        @(negedge clk_sys_i);
        pclr = 1'b0;
        {wen, wwen} = 2'b11;
        repeat (4) begin
            repeat (t - 4) @(negedge clk_sys_i);
            chk("warn_irq", 1, irq);
            wrst = 1'b1;
            @(negedge clk_sys_i);
            wrst = 1'b0;
        end
        chk("fed_core_rst", 0, core);
        wait_core(1, t + 8, n);
        rng("wdog_fire", n, t, t + 2);
        chk("warn_before_rst", 1, irq);
        chk("wdog_oe", 1, oe);
        wen = 1'b0;
        wait_core(0, 20, n);
        rng("wdog_len", n, WDOG_RESET_CYCLES, WDOG_RESET_CYCLES);
        chk("por_flag_kept", 0, wdctl[WDCTL_POR_BIT]);
        chk("restart_addr", RESTART_ADDR, raddr);
        repeat (10) @(negedge clk_sys_i);
        chk("wdog_no_echo", 0, core);
        $display("test watchdog done");
        pfail = 1'b1;
        wait_core(1, 10, n);
        rng("pfail_entry", n, 0, 8);
        repeat (30) @(negedge clk_sys_i);
        chk("pfail_hold", 1, core);
        pfail = 1'b0;
        wait_core(0, 14, n);
        rng("pfail_exit", n, 0, 10);
        $display("test powerfail done");
        rst_b_i = 1'b0;
        @(negedge clk_sys_i);
        chk("rerun_core_rst", 1, core);
        chk("rerun_por_flag", 1, wdctl[WDCTL_POR_BIT]);
        chk("rerun_pin_oe", 1, oe);
        chk("rerun_irq", 0, irq);
        rst_b_i = 1'b1;
        wait_core(0, HOLD + 40, n);
        rng("rerun_hold", n, HOLD, HOLD + 8);
        $display("test rerun done");
        conclude();
    end
endmodule : tb_top
`default_nettype wire
